// file: src/lpm_pkg.sv
/*
  Package for the low-power mode controller: register map, field positions,
  reset values, timing counts and state encoding.
  Assumes one 100 MHz system clock standing in for the oscillator.
*/
package lpm_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CFG_OFS    = 12'h00c;
  localparam logic [11:0] CTRL_OFS   = 12'h010;
  localparam logic [11:0] STATUS_OFS = 12'h014;
  // ----------------------------------------------------------------
  // Config register fields
  // ----------------------------------------------------------------
  localparam int RISE_BIT  = 6;
  localparam int FALL_BIT  = 5;
  localparam int ALLOW_BIT = 4;
  localparam int SLOW_BIT  = 1;
  localparam logic [7:0] CFG_RESET = 8'h10;
  // ----------------------------------------------------------------
  // Control register fields (write one to act, except the mask bit, which takes the written value)
  // ----------------------------------------------------------------
  localparam int CTRL_STOP_BIT  = 0;
  localparam int CTRL_WAIT_BIT  = 1;
  localparam int CTRL_IMASK_BIT = 2;
  localparam int CTRL_ICLR_BIT  = 3;
  localparam int CTRL_SWRST_BIT = 4;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SHORT_DELAY  = 16;
  localparam int LONG_DELAY   = 4064;
  localparam int NORM_DIV     = 2;
  localparam int SLOW_DIV     = 32;
  localparam int RST_PULSE_NS = 100;
  localparam int CLK_NS       = 10;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] EXT_VEC   = 16'h1ffa;
  localparam logic [15:0] RESET_VEC = 16'h1ffe;
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LPM_RUN, LPM_STOP, LPM_SETTLE, LPM_WAIT} lpm_state_t;
endpackage

// file: src/lpm_ctrl.sv
/*
  Low-power mode controller: deep stop, light wait, slow clock divider,
  external interrupt trigger config and reset pin handling.
  Assumes an AXI4-Lite master on clk_in, a CPU core that asks for stop/wait
  through the control register, and raw pins that are synchronised here.
*/
// Contract
// - Stop halts oscillator and all peripherals
// - Stop exits only on irq or reset
// - Stop entry clears interrupt mask bit
// - Stop entry clears slow clock select
// - Wake vectors to irq or reset vector
// - Hold CPU 16 or 4064 cycles after restart
// - Resume by servicing waking cause
// - Stacking only when leaving stop (code also strobes stacking on an irq, timer or serial exit from wait)
// - Registers and pins frozen in stop
// - Stop resets watchdog, freezes serial, timer, nvm
// - Pulse outputs hold, converter off in stop
// - Wait suspends only CPU
// - Wait clears mask, keeps irq allow
// - Wait ends on irq, timer, serial, reset
// - Reset exit full reset, else unchanged
// - Slow bit selects divide 32 else 2
// - External and power-on reset clear slow bit
// - Two trigger bits plus allow bit
// - Trigger bits writable only when masked
// - Changing trigger clears pending interrupt
// - Reset pin low forces start-up state
// - Internal reset drives reset pin open-drain
module lpm_ctrl #(
  parameter bit LONG_SETTLE = 1'b1,
  parameter bit WDOG_IN_WAIT = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Pins
  input  wire logic        irq_pin_in,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_out,
  // Wake sources and internal reset requests
  input  wire logic        timer_irq_in,
  input  wire logic        serial_irq_in,
  input  wire logic        watchdog_timeout_in,
  // Clock and module control outputs
  output logic             bus_clk_en_out,
  output logic             osc_run_out,
  output logic             cpu_hold_out,
  output logic             periph_freeze_out,
  output logic             watchdog_clear_out,
  output logic             watchdog_run_out,
  output logic             nvm_read_only_out,
  output logic             converter_off_out,
  output logic             pulse_hold_out,
  output logic             sys_reset_out,
  output logic             irq_mask_out,
  output logic             ext_irq_req_out,
  output logic             stack_req_out,
  output logic [15:0]      vector_out,
  output logic             vector_valid_out
);
  localparam int SETTLE_CYC = LONG_SETTLE ? lpm_pkg::LONG_DELAY : lpm_pkg::SHORT_DELAY;
  localparam int SETTLE_W = $clog2(lpm_pkg::LONG_DELAY * lpm_pkg::NORM_DIV + 1);

  if (lpm_pkg::SLOW_DIV % lpm_pkg::NORM_DIV != 0 || lpm_pkg::SLOW_DIV > 32) begin : g_bad_div
    $error("Divider ratio must be whole and fit the five-bit counter");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] irq_sync_r;
  logic [1:0] rst_sync_r;
  logic       irq_prev_r;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_sync_r <= 2'b11;
      rst_sync_r <= 2'b11;
      irq_prev_r <= 1'b1;
    end else begin
      irq_sync_r <= {irq_sync_r[0], irq_pin_in};
      rst_sync_r <= {rst_sync_r[0], reset_pin_in};
      irq_prev_r <= irq_sync_r[1];
    end
  end
  logic irq_lvl;
  logic pin_reset;
  assign irq_lvl   = irq_sync_r[1];
  assign pin_reset = ~rst_sync_r[1];

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  lpm_pkg::lpm_state_t state_r;
  logic [7:0]          cfg_r;
  logic                imask_r;
  logic                pend_r;
  logic                wake_reset_r;
  logic [SETTLE_W-1:0] settle_r;
  logic [4:0]          div_r;
  logic [3:0]          pulse_r;
  logic                sw_rst_r;

  // AXI write channel capture
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;

  logic wr_fire;
  assign s_axi_awready_out = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready_out  = ~w_hold_r & ~bvalid_r;
  assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata_in;
        wstrb_r  <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
      end else if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out  = 2'b00;

  // Decoded write strobes
  logic wr_cfg;
  logic wr_ctrl;
  assign wr_cfg  = wr_fire && awaddr_r == lpm_pkg::CFG_OFS && wstrb_r[0];
  assign wr_ctrl = wr_fire && awaddr_r == lpm_pkg::CTRL_OFS && wstrb_r[0];

  logic stop_req;
  logic wait_req;
  logic pend_clr;
  assign stop_req = wr_ctrl && wdata_r[lpm_pkg::CTRL_STOP_BIT] && state_r == lpm_pkg::LPM_RUN;
  assign wait_req = wr_ctrl && wdata_r[lpm_pkg::CTRL_WAIT_BIT] && !wdata_r[lpm_pkg::CTRL_STOP_BIT]
                    && state_r == lpm_pkg::LPM_RUN;
  assign pend_clr = wr_ctrl && wdata_r[lpm_pkg::CTRL_ICLR_BIT];

  // ----------------------------------------------------------------
  // External interrupt trigger
  // ----------------------------------------------------------------
  logic irq_event;
  logic trig_change;
  always_comb begin
    unique case ({cfg_r[lpm_pkg::RISE_BIT], cfg_r[lpm_pkg::FALL_BIT]})
      2'b00:   irq_event = ~irq_lvl;
      2'b01:   irq_event = irq_prev_r & ~irq_lvl;
      2'b10:   irq_event = ~irq_prev_r & irq_lvl;
      default: irq_event = irq_prev_r ^ irq_lvl;
    endcase
  end
  assign trig_change = wr_cfg && imask_r &&
                       wdata_r[lpm_pkg::RISE_BIT:lpm_pkg::FALL_BIT] != cfg_r[lpm_pkg::RISE_BIT:lpm_pkg::FALL_BIT];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pend_r <= 1'b0;
    end else if (sys_reset_out) begin
      pend_r <= 1'b0;
    end else if (irq_event && cfg_r[lpm_pkg::ALLOW_BIT]) begin
      pend_r <= 1'b1;
    end else if (trig_change || pend_clr) begin
      pend_r <= 1'b0;
    end
  end
  assign ext_irq_req_out = pend_r;

  // ----------------------------------------------------------------
  // Config register and interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cfg_r <= lpm_pkg::CFG_RESET;
    end else if (sys_reset_out) begin
      cfg_r <= lpm_pkg::CFG_RESET;
    end else if (stop_req) begin
      cfg_r[lpm_pkg::SLOW_BIT] <= 1'b0;
    end else if (wr_cfg && state_r == lpm_pkg::LPM_RUN) begin
      cfg_r[lpm_pkg::ALLOW_BIT] <= wdata_r[lpm_pkg::ALLOW_BIT];
      cfg_r[lpm_pkg::SLOW_BIT]  <= wdata_r[lpm_pkg::SLOW_BIT];
      if (imask_r) begin
        cfg_r[lpm_pkg::RISE_BIT] <= wdata_r[lpm_pkg::RISE_BIT];
        cfg_r[lpm_pkg::FALL_BIT] <= wdata_r[lpm_pkg::FALL_BIT];
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      imask_r <= 1'b1;
    end else if (sys_reset_out) begin
      imask_r <= 1'b1;
    end else if (stop_req || wait_req) begin
      imask_r <= 1'b0;
    end else if (wr_ctrl && state_r == lpm_pkg::LPM_RUN) begin
      imask_r <= wdata_r[lpm_pkg::CTRL_IMASK_BIT];
    end
  end
  assign irq_mask_out = imask_r;

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  logic wake_irq;
  logic settle_done;
  assign wake_irq    = pend_r && cfg_r[lpm_pkg::ALLOW_BIT];
  assign settle_done = settle_r == SETTLE_W'(SETTLE_CYC * lpm_pkg::NORM_DIV - 1);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r      <= lpm_pkg::LPM_RUN;
      wake_reset_r <= 1'b0;
      settle_r     <= '0;
    end else begin
      unique case (state_r)
        lpm_pkg::LPM_RUN: begin
          if (stop_req) state_r <= lpm_pkg::LPM_STOP;
          else if (wait_req) state_r <= lpm_pkg::LPM_WAIT;
        end
        lpm_pkg::LPM_STOP: begin
          if (pin_reset || wake_irq) begin
            state_r      <= lpm_pkg::LPM_SETTLE;
            wake_reset_r <= pin_reset;
            settle_r     <= '0;
          end
        end
        lpm_pkg::LPM_SETTLE: begin
          if (pin_reset) wake_reset_r <= 1'b1;
          if (settle_done) state_r <= lpm_pkg::LPM_RUN;
          else settle_r <= settle_r + SETTLE_W'(1);
        end
        lpm_pkg::LPM_WAIT: begin
          if (pin_reset || wake_irq || timer_irq_in || serial_irq_in) state_r <= lpm_pkg::LPM_RUN;
        end
      endcase
      if (sys_reset_out && state_r != lpm_pkg::LPM_STOP && state_r != lpm_pkg::LPM_SETTLE) begin
        state_r <= lpm_pkg::LPM_RUN;
      end
    end
  end

  // Wake vector and stacking strobe on return to run
  logic leave_settle;
  logic leave_wait_irq;
  assign leave_settle   = state_r == lpm_pkg::LPM_SETTLE && settle_done;
  assign leave_wait_irq = state_r == lpm_pkg::LPM_WAIT && !pin_reset &&
                          (wake_irq || timer_irq_in || serial_irq_in);
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      vector_out       <= lpm_pkg::RESET_VEC;
      vector_valid_out <= 1'b0;
      stack_req_out    <= 1'b0;
    end else begin
      vector_valid_out <= leave_settle;
      stack_req_out    <= (leave_settle && !wake_reset_r && !pin_reset) || leave_wait_irq;
      if (leave_settle) vector_out <= (wake_reset_r || pin_reset) ? lpm_pkg::RESET_VEC
                                                                  : lpm_pkg::EXT_VEC;
    end
  end

  // ----------------------------------------------------------------
  // System reset and reset pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pulse_r  <= 4'(lpm_pkg::RST_PULSE_CYC);
      sw_rst_r <= 1'b0;
    end else begin
      sw_rst_r <= wr_ctrl && wdata_r[lpm_pkg::CTRL_SWRST_BIT];
      if (watchdog_timeout_in || sw_rst_r) pulse_r <= 4'(lpm_pkg::RST_PULSE_CYC);
      else if (pulse_r != 4'h0) pulse_r <= pulse_r - 4'h1;
    end
  end
  assign reset_pin_out    = 1'b0;
  assign reset_pin_oe_out = pulse_r != 4'h0;
  // Reset in stop is delayed until the settle count ends so the vector fetch sees it
  assign sys_reset_out    = reset_in || ((pin_reset || pulse_r != 4'h0) &&
                            state_r != lpm_pkg::LPM_STOP && state_r != lpm_pkg::LPM_SETTLE) ||
                            (leave_settle && (wake_reset_r || pin_reset));

  // ----------------------------------------------------------------
  // Bus clock divider
  // ----------------------------------------------------------------
  logic [4:0] div_last;
  assign div_last = cfg_r[lpm_pkg::SLOW_BIT] ? 5'(lpm_pkg::SLOW_DIV - 1) : 5'(lpm_pkg::NORM_DIV - 1);
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_r <= 5'h00;
    end else if (div_r >= div_last) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end
  assign bus_clk_en_out = div_r == 5'h00 && osc_run_out;

  // ----------------------------------------------------------------
  // Module controls
  // ----------------------------------------------------------------
  logic in_stop;
  assign in_stop           = state_r == lpm_pkg::LPM_STOP;
  assign osc_run_out       = !in_stop;
  assign periph_freeze_out = in_stop;
  assign watchdog_clear_out = stop_req;
  assign watchdog_run_out  = state_r == lpm_pkg::LPM_RUN || (state_r == lpm_pkg::LPM_WAIT && WDOG_IN_WAIT);
  assign nvm_read_only_out = in_stop || state_r == lpm_pkg::LPM_SETTLE;
  assign converter_off_out = in_stop;
  assign pulse_hold_out    = in_stop;
  assign cpu_hold_out      = state_r != lpm_pkg::LPM_RUN;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else if (!rvalid_r && s_axi_arvalid_in) begin
      rvalid_r <= 1'b1;
      unique case (s_axi_araddr_in)
        lpm_pkg::CFG_OFS:    rdata_r <= {24'h000000, cfg_r};
        lpm_pkg::CTRL_OFS:   rdata_r <= {29'h0, imask_r, 2'b00};
        lpm_pkg::STATUS_OFS: rdata_r <= {27'h0, wake_reset_r, pend_r, cpu_hold_out, 2'(state_r)};
        default:             rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_rvalid_out  = rvalid_r;
  assign s_axi_rdata_out   = rdata_r;
  assign s_axi_rresp_out   = 2'b00;
endmodule // lpm_ctrl

// file: bench/lpm_ctrl_assertions.sv
/*
  Checker for the low-power mode controller, bound to its top ports.
  Assumes one clock domain with the active-high asynchronous reset.
*/
module lpm_ctrl_chk (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        reset_in,
  // Watched outputs
  input wire logic        bus_clk_en_out,
  input wire logic        osc_run_out,
  input wire logic        cpu_hold_out,
  input wire logic        periph_freeze_out,
  input wire logic        converter_off_out,
  input wire logic        pulse_hold_out,
  input wire logic        nvm_read_only_out,
  input wire logic        watchdog_clear_out,
  input wire logic        watchdog_run_out,
  input wire logic        irq_mask_out,
  input wire logic        stack_req_out,
  input wire logic [15:0] vector_out,
  input wire logic        vector_valid_out,
  input wire logic        reset_pin_out,
  input wire logic        reset_pin_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       oe_prev_r;
  logic [7:0] oe_cnt_r;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Length of each internally started pin pulse
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      oe_prev_r <= 1'b1;
      oe_cnt_r  <= 8'h00;
    end else begin
      oe_prev_r <= reset_pin_oe_out;
      if (reset_pin_oe_out && !oe_prev_r) oe_cnt_r <= 8'h01;
      else if (reset_pin_oe_out && oe_cnt_r != 8'h00) oe_cnt_r <= oe_cnt_r + 8'h01;
      else oe_cnt_r <= 8'h00;
    end
  end
  chk_stop_freeze: assert property (!osc_run_out |-> periph_freeze_out && converter_off_out && pulse_hold_out)
    else $error("peripherals not frozen in stop");
  chk_stop_no_clk: assert property (!osc_run_out |-> !bus_clk_en_out)
    else $error("bus clock runs in stop");
  chk_stop_cpu_nvm: assert property (!osc_run_out |-> cpu_hold_out && nvm_read_only_out)
    else $error("cpu or nvm active in stop");
  chk_stop_mask: assert property (!osc_run_out |-> !irq_mask_out)
    else $error("mask set in stop");
  chk_stop_wdog: assert property ($fell(osc_run_out) |-> $past(watchdog_clear_out) || watchdog_clear_out)
    else $error("watchdog not cleared at stop entry");
  chk_stop_wdog_off: assert property (!osc_run_out |-> !watchdog_run_out)
    else $error("watchdog runs in stop");
  chk_vec_value: assert property (vector_valid_out |-> vector_out == 16'h1ffa || vector_out == 16'h1ffe)
    else $error("bad wake vector");
  chk_stack_exit: assert property (stack_req_out |-> osc_run_out ##1 !stack_req_out)
    else $error("stacking outside exit");
  chk_clk_div: assert property (bus_clk_en_out |=> !bus_clk_en_out)
    else $error("bus clock enable too long");
  chk_pin_low: assert property (reset_pin_oe_out |-> !reset_pin_out)
    else $error("reset pin driven high");
  chk_pin_pulse: assert property ($fell(reset_pin_oe_out) && oe_cnt_r != 8'h00 |-> oe_cnt_r == 8'h0a)
    else $error("reset pin pulse length wrong");
endmodule // lpm_ctrl_chk

bind lpm_ctrl lpm_ctrl_chk u_chk (.clk_in, .reset_in, .bus_clk_en_out, .osc_run_out, .cpu_hold_out,
  .periph_freeze_out, .converter_off_out, .pulse_hold_out, .nvm_read_only_out, .watchdog_clear_out, .watchdog_run_out,
  .irq_mask_out, .stack_req_out, .vector_out, .vector_valid_out, .reset_pin_out, .reset_pin_oe_out);

// file: bench/lpm_far_side.sv
/*
  Far side of the controller: pins and peripheral interrupt sources.
  Assumes the bench asks for pin levels and interrupt events.
*/
module lpm_far_side (
  // Core status
  input  wire logic cpu_hold_in,
  // Bench requests
  input  wire logic irq_low_in,
  input  wire logic rst_low_in,
  input  wire logic tmr_req_in,
  input  wire logic ser_req_in,
  input  wire logic wdt_req_in,
  // Open-drain reset from the device
  input  wire logic rst_oe_in,
  input  wire logic rst_drv_in,
  // Towards the device
  output logic      irq_pin_out,
  output logic      rst_pin_out,
  output logic      timer_irq_out,
  output logic      serial_irq_out,
  output logic      wdt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign irq_pin_out = !irq_low_in;
  // Pulled up; low when either party pulls it down
  assign rst_pin_out = !rst_low_in && !(rst_oe_in && !rst_drv_in);
  // Flags drop once the core is released to service them
  assign timer_irq_out  = tmr_req_in && cpu_hold_in;
  assign serial_irq_out = ser_req_in && cpu_hold_in;
  assign wdt_out        = wdt_req_in;
endmodule // lpm_far_side

// file: bench/tb.sv
/*
  Self-checking bench for the low-power mode controller.
  Assumes the short settle option and an AXI4-Lite master of its own.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, reset_in, awv, wv, br, arv, rr, awr, wr, bv, ard, rv;
  logic [11:0] aw, ar;
  logic [31:0] wd, rd, d, seed;
  logic [3:0] ws;
  logic irq_low, rst_low, tmr, ser, wdt, irq_pin, rst_pin, tmr_irq, ser_irq, wdt_p;
  logic oe, drv, en, osc, hold, srst, stk, vv;
  logic [15:0] vec;
  int failures, num_checks, cfg_m, msk_m, n;
  lpm_ctrl #(.LONG_SETTLE(1'b0)) uut (.clk_in, .reset_in, .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ar), .s_axi_arvalid_in(arv), .s_axi_arready_out(ard), .s_axi_rdata_out(rd),
    .s_axi_rresp_out(), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .irq_pin_in(irq_pin),
    .reset_pin_in(rst_pin), .reset_pin_out(drv), .reset_pin_oe_out(oe), .timer_irq_in(tmr_irq),
    .serial_irq_in(ser_irq), .watchdog_timeout_in(wdt_p), .bus_clk_en_out(en), .osc_run_out(osc),
    .cpu_hold_out(hold), .periph_freeze_out(), .watchdog_clear_out(), .watchdog_run_out(),
    .nvm_read_only_out(), .converter_off_out(), .pulse_hold_out(), .sys_reset_out(srst),
    .irq_mask_out(), .ext_irq_req_out(), .stack_req_out(stk), .vector_out(vec), .vector_valid_out(vv));
  lpm_far_side u_far (.cpu_hold_in(hold), .irq_low_in(irq_low), .rst_low_in(rst_low), .tmr_req_in(tmr),
    .ser_req_in(ser), .wdt_req_in(wdt), .rst_oe_in(oe), .rst_drv_in(drv), .irq_pin_out(irq_pin),
    .rst_pin_out(rst_pin), .timer_irq_out(tmr_irq), .serial_irq_out(ser_irq), .wdt_out(wdt_p));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ----
  // Helpers
  // ----
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int k);
    if (k >= 300) begin
      chk("timeout", 0, 1);
      print_verdict();
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] r;
    int k;
    r = rnd();
    @(posedge clk_in);
    aw <= a; wd <= {r[31:8], v}; ws <= {r[2:0], 1'b1};
    awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_in);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    tmo(k);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input int e, input string nm);
    int k;
    @(posedge clk_in);
    ar <= a; arv <= 1'b1; rr <= 1'b1;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_in);
      if (ard) arv <= 1'b0;
      if (rv) begin
        d = rd;
        break;
      end
    end
    rr <= 1'b0;
    tmo(k);
    chk(nm, e[31:0] & m, d & m);
  endtask
  task automatic wcfg(input logic [7:0] v);
    axw(lpm_pkg::CFG_OFS, v);
    cfg_m = msk_m ? (v & 8'h72) : ((cfg_m & 8'h60) | (v & 8'h12));
  endtask
  task automatic wctl(input logic [7:0] v);
    axw(lpm_pkg::CTRL_OFS, v);
    msk_m = v[2] && !v[0] && !v[1];
    if (v[0]) cfg_m &= 8'h70;
  endtask
  // Waits on 0 vector, 1 core release, 2 reset end, 3 oscillator; n counts edges
  task automatic wt(input int s);
    for (n = 1; n < 300; n++) begin
      @(posedge clk_in);
      if ((s == 0 && vv) || (s == 1 && !hold) || (s == 2 && !srst) || (s == 3 && osc)) break;
    end
    tmo(n);
  endtask
  task automatic cnt(input int s, input int cyc);
    repeat (s == 0 ? 40 : 0) @(posedge clk_in);
    n = 0;
    repeat (cyc) begin
      @(posedge clk_in);
      if ((s == 0 ? en : oe) === 1'b1) n++;
    end
  endtask
  task automatic rst_wait();
    repeat (20) @(posedge clk_in);
    wt(2);
    cfg_m = 8'h10;
    msk_m = 1;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    {aw, ar, wd, ws, awv, wv, br, arv, rr} = '0;
    {irq_low, rst_low, tmr, ser, wdt} = '0;
    seed = 32'h43;
    failures = 0;
    num_checks = 0;
    reset_in = 1'b1;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    rst_wait();
    rdc(lpm_pkg::CFG_OFS, 32'h72, cfg_m, "cfg_reset");
    rdc(lpm_pkg::CTRL_OFS, 32'h04, 4, "mask_reset");
    rdc(12'h020, 32'hffffffff, 0, "unmapped");
    $display("test reset done");
    // Count bus clock enables with slow clock on, then off
    wcfg(8'h12);
    cnt(0, 64);
    chk("div32", 2, n);
    wcfg(8'h10);
    cnt(0, 64);
    chk("div2", 32, n);
    $display("test slow done");
    for (int t = 0; t < 4; t++) begin
      wcfg(8'h10 | (t << 5));
      rdc(lpm_pkg::CFG_OFS, 32'h72, cfg_m, "trigger");
    end
    wcfg(8'h30);
    irq_low <= 1'b1;
    repeat (6) @(posedge clk_in);
    irq_low <= 1'b0;
    repeat (4) @(posedge clk_in);
    rdc(lpm_pkg::STATUS_OFS, 32'h08, 8, "pending");
    wcfg(8'h50);
    rdc(lpm_pkg::STATUS_OFS, 32'h08, 0, "pend_clear");
    wctl(8'h00);
    wcfg(8'h10);
    rdc(lpm_pkg::CFG_OFS, 32'h72, cfg_m, "trig_locked");
    wctl(8'h04);
    wcfg(8'h12);
    $display("test trigger done");
    wctl(8'h01);
    chk("osc_off", 0, osc);
    rdc(lpm_pkg::STATUS_OFS, 32'h07, 5, "st_stop");
    rdc(lpm_pkg::CFG_OFS, 32'h72, cfg_m, "slow_clr");
    rdc(lpm_pkg::CTRL_OFS, 32'h04, 0, "mask_clr");
    ser <= 1'b1;
    repeat (10) @(posedge clk_in);
    ser <= 1'b0;
    chk("no_wake", 0, osc);
    irq_low <= 1'b1;
    wt(3);
    wt(0);
    chk("settle", 1, n >= 31 && n <= 34);
    chk("irq_vec", 16'h1ffa, vec);
    chk("stack", 1, stk);
    irq_low <= 1'b0;
    wctl(8'h0c);
    wctl(8'h01);
    rst_low <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_low <= 1'b0;
    wt(0);
    chk("rst_vec", 16'h1ffe, vec);
    chk("rst_stack", 0, stk);
    rst_wait();
    rdc(lpm_pkg::CFG_OFS, 32'h72, cfg_m, "stop_rst");
    rdc(lpm_pkg::CTRL_OFS, 32'h04, 4, "stop_rst_mask");
    $display("test stop done");
    for (int s = 0; s < 2; s++) begin
      wctl(8'h02);
      chk("wait_run", 3, {osc, hold});
      rdc(lpm_pkg::CFG_OFS, 32'h72, cfg_m, "allow_kept");
      rdc(lpm_pkg::CTRL_OFS, 32'h04, 0, "wait_mask");
      if (s == 0) tmr <= 1'b1;
      else ser <= 1'b1;
      wt(1);
      rdc(lpm_pkg::CFG_OFS, 32'h72, cfg_m, "wait_keep");
      tmr <= 1'b0;
      ser <= 1'b0;
      wctl(8'h04);
    end
    $display("test wait done");
    wcfg(8'h12);
    rst_low <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_low <= 1'b0;
    rst_wait();
    rdc(lpm_pkg::CFG_OFS, 32'h72, cfg_m, "ext_rst");
    for (int s = 0; s < 2; s++) begin
      wcfg(8'h12);
      if (s == 0) begin
        wdt <= 1'b1;
        @(posedge clk_in);
        wdt <= 1'b0;
      end else wctl(8'h10);
      cnt(1, 30);
      chk("pin_pulse", 10, n);
      rst_wait();
      rdc(lpm_pkg::CFG_OFS, 32'h72, cfg_m, "wdog_rst");
    end
    $display("test reset pin done");
    print_verdict();
  end
endmodule // tb
